// ---- design/dspcls_top.sv ----
// module: extension opcode classifier, one registered verdict per word
`timescale 1ns/1ps
module dspcls_top
    import dspcls_pkg::*;
#(
    parameter bit HAS_DSP   = 1'b1,
    parameter bit HAS_DEBUG = 1'b0,
    parameter bit IS_REL2   = 1'b1
)(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    // fetch side
    input  wire logic        insn_valid_i,
    input  wire logic [31:0] insn_i,
    input  wire logic        cop_usable_i,
    // sub-decode hints from minor tables
    input  wire logic [2:0]  minor_attr_i,
    // verdict
    output logic             out_valid_o,
    output dspcls_out_t      outcome_o,
    output dspcls_exc_t      exc_cause_o,
    output logic             dsp_insn_o,
    output logic [9:0]       minor_o,
    output logic             obsolete_o
);
    dspcls_map_if mif ();
    assign mif.row = insn_i[ROW_MSB:ROW_LSB];
    assign mif.col = insn_i[COL_MSB:COL_LSB];

    dspcls_major_map u_map (
        .m (mif)
    );

    // minor_attr_i codes: 0 valid,1 rsvd,2 ext,3 debug,4 rel2,5 obsolete
    wire [2:0] mattr = minor_attr_i;
    wire is_pool_w   = ({mif.row, mif.col} == DSP_POOL_OP);

    wire ri_rsvd_w  = (mif.attr == DSPCLS_ATTR_RSVD) || (is_pool_w && mattr == 3'h1);
    wire ri_high_w  = (mif.attr == DSPCLS_ATTR_HIGHER);
    wire cpu_w      = (mif.attr == DSPCLS_ATTR_PARTNER) && mif.cop && !cop_usable_i;
    wire ri_part_w  = (mif.attr == DSPCLS_ATTR_PARTNER) && !cpu_w;
    wire ri_dbg_w   = is_pool_w && (mattr == 3'h3) && !HAS_DEBUG;
    wire ri_ext_w   = is_pool_w && (mattr == 3'h2) && !HAS_DSP;
    wire ri_rel_w   = is_pool_w && (mattr == 3'h4) && !IS_REL2;
    wire dsp_w      = is_pool_w && (mattr == 3'h2) && HAS_DSP;
    wire field_w    = (mif.attr == DSPCLS_ATTR_FIELD) && !dsp_w;

    // only minor codes 6 and 7 leave a field class
    wire sub_w      = field_w && (mattr[2:1] == 2'h3);

    wire ri_w = ri_rsvd_w | ri_high_w | ri_part_w | ri_dbg_w | ri_ext_w | ri_rel_w;
    wire dspcls_exc_t exc_w = cpu_w ? DSPCLS_EXC_CPU :
                              ri_w  ? DSPCLS_EXC_RI : DSPCLS_EXC_NONE;
    wire dspcls_out_t out_w = (exc_w != DSPCLS_EXC_NONE) ? DSPCLS_OUT_EXC :
                              sub_w ? DSPCLS_OUT_FIELD :
                              DSPCLS_OUT_VALID;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_valid_o <= 1'b0;
            outcome_o   <= DSPCLS_OUT_VALID;
            exc_cause_o <= DSPCLS_EXC_NONE;
            dsp_insn_o  <= 1'b0;
            minor_o     <= 10'h000;
            obsolete_o  <= 1'b0;
        end else begin
            out_valid_o <= insn_valid_i;
            outcome_o   <= out_w;
            exc_cause_o <= exc_w;
            dsp_insn_o  <= insn_valid_i && dsp_w && !ri_w;
            minor_o     <= insn_i[MINOR_MSB:MINOR_LSB];
            obsolete_o  <= insn_valid_i && is_pool_w && (mattr == 3'h5);
        end
    end

    rsvd_exc_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        insn_valid_i && ri_rsvd_w |=> exc_cause_o == DSPCLS_EXC_RI)
        else $error("reserved code did not raise RI");
    high_exc_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        insn_valid_i && ri_high_w |=> outcome_o == DSPCLS_OUT_EXC)
        else $error("higher level code not trapped");
    cop_unusable_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        insn_valid_i && cpu_w |=> exc_cause_o == DSPCLS_EXC_CPU)
        else $error("coprocessor unusable missing");
    cop_allowed_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        insn_valid_i && mif.attr == DSPCLS_ATTR_PARTNER && cop_usable_i
        |=> exc_cause_o == DSPCLS_EXC_RI)
        else $error("usable coprocessor code not trapped as RI");
    one_outcome_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        out_valid_o |-> ((outcome_o == DSPCLS_OUT_EXC) == (exc_cause_o != DSPCLS_EXC_NONE)))
        else $error("outcome and cause disagree");
    dsp_clean_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        dsp_insn_o |-> outcome_o == DSPCLS_OUT_VALID && exc_cause_o == DSPCLS_EXC_NONE)
        else $error("dsp instruction with another outcome");
    verdict_lat_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        out_valid_o == $past(insn_valid_i))
        else $error("verdict not one cycle after word");
    dsp_pool_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        dsp_insn_o |-> $past(insn_i[31:26]) == DSP_POOL_OP)
        else $error("dsp outside pool");
    dsp_found_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        insn_valid_i && is_pool_w && mattr == 3'h2 && HAS_DSP |=> dsp_insn_o)
        else $error("dsp instruction not recognised");
    field_cls_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        out_valid_o && outcome_o == DSPCLS_OUT_FIELD |-> $past(insn_i[31:26]) == DSP_POOL_OP)
        else $error("field class outside pool");
    field_minor_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        insn_valid_i && is_pool_w && mattr[2:1] == 2'h3 |=> outcome_o == DSPCLS_OUT_FIELD)
        else $error("field class not passed on");
    minor_pass_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        out_valid_o |-> minor_o == $past(insn_i[MINOR_MSB:MINOR_LSB]))
        else $error("minor field not carried");
    debug_opt_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        insn_valid_i && ri_dbg_w |=> exc_cause_o == DSPCLS_EXC_RI)
        else $error("debug code not trapped");
    debug_impl_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        insn_valid_i && is_pool_w && mattr == 3'h3 && HAS_DEBUG
        |=> outcome_o == DSPCLS_OUT_VALID)
        else $error("present debug code not executed");
    ext_absent_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        insn_valid_i && ri_ext_w |=> !dsp_insn_o && outcome_o == DSPCLS_OUT_EXC)
        else $error("missing extension not trapped");
    rel_two_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        insn_valid_i && ri_rel_w |=> exc_cause_o == DSPCLS_EXC_RI)
        else $error("release two code not trapped");
    rel_two_ok_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        insn_valid_i && is_pool_w && mattr == 3'h4 && IS_REL2
        |=> outcome_o == DSPCLS_OUT_VALID && exc_cause_o == DSPCLS_EXC_NONE)
        else $error("release two code not executed");
    obsolete_flag_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        insn_valid_i && is_pool_w && mattr == 3'h5
        |=> obsolete_o && outcome_o == DSPCLS_OUT_VALID)
        else $error("obsolete code not flagged");
    row_col_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        insn_valid_i && insn_i[31:29] == 3'h6 && insn_i[28:26] == 3'h2
        |=> exc_cause_o == DSPCLS_EXC_RI)
        else $error("row column lookup wrong");

    dsp_seen_c: cover property (@(posedge clock_i) disable iff (!resetn_i) dsp_insn_o);
    ri_seen_c:  cover property (@(posedge clock_i) disable iff (!resetn_i)
        out_valid_o && exc_cause_o == DSPCLS_EXC_RI);
    cpu_seen_c: cover property (@(posedge clock_i) disable iff (!resetn_i)
        out_valid_o && exc_cause_o == DSPCLS_EXC_CPU);
    field_seen_c: cover property (@(posedge clock_i) disable iff (!resetn_i)
        out_valid_o && outcome_o == DSPCLS_OUT_FIELD);
    obs_seen_c: cover property (@(posedge clock_i) disable iff (!resetn_i)
        out_valid_o && obsolete_o);
endmodule

// ---- pkg/dspcls_pkg.sv ----
// package: constants and types for the extension opcode classifier
// Functional notes
// - The major opcode entry is found by instruction bits 31..29 as row and 28..26 as column.
// - A code reserved for future use raises a Reserved Instruction exception and does nothing.
// - A field-class code is not a full instruction and is resolved through a further field.
// - A code valid only at a higher architecture level raises Reserved Instruction here.
// - Unimplemented partner codes raise Reserved Instruction, or Coprocessor Unusable if access is denied.
// - Debug support codes are optional, raise Reserved Instruction if absent and match the map if present.
// - Extension codes raise Reserved Instruction when the extension is not present.
// - Second-release codes execute on second-release parts and raise Reserved Instruction on first-release.
// - Signal-processing instructions are recognised only in one major pool and sub-decoded there.
package dspcls_pkg;
    localparam int ROW_MSB     = 31;
    localparam int ROW_LSB     = 29;
    localparam int COL_MSB     = 28;
    localparam int COL_LSB     = 26;
    localparam int MINOR_MSB   = 9;
    localparam int MINOR_LSB   = 0;
    localparam int CLS_LATENCY = 1;

    // map position of the pool holding the signal-processing instructions
    localparam logic [5:0] DSP_POOL_OP   = 6'h00;
    // encoding-map attribute of each major code
    typedef enum logic [3:0] {
        DSPCLS_ATTR_VALID,
        DSPCLS_ATTR_RSVD,
        DSPCLS_ATTR_FIELD,
        DSPCLS_ATTR_HIGHER,
        DSPCLS_ATTR_PARTNER,
        DSPCLS_ATTR_DEBUG,
        DSPCLS_ATTR_EXT,
        DSPCLS_ATTR_OBSOLETE,
        DSPCLS_ATTR_REL2
    } dspcls_attr_t;

    typedef enum logic [1:0] {
        DSPCLS_OUT_VALID,
        DSPCLS_OUT_FIELD,
        DSPCLS_OUT_EXC
    } dspcls_out_t;

    typedef enum logic [1:0] {
        DSPCLS_EXC_NONE,
        DSPCLS_EXC_RI,
        DSPCLS_EXC_CPU
    } dspcls_exc_t;
endpackage

// ---- pkg/dspcls_map_if.sv ----
// interface: major-code lookup between classifier and map
`timescale 1ns/1ps
interface dspcls_map_if;
    import dspcls_pkg::*;
    logic [2:0]   row;
    logic [2:0]   col;
    dspcls_attr_t attr;
    logic         cop;
    modport requester (output row, output col, input attr, input cop);
    modport map       (input row, input col, output attr, output cop);
endinterface

// ---- design/dspcls_major_map.sv ----
// module: major opcode encoding map lookup
`timescale 1ns/1ps
module dspcls_major_map
    import dspcls_pkg::*;
(
    dspcls_map_if.map m
);
    wire [5:0] code = {m.row, m.col};
    wire rsvd_w  = (m.row <= 3'h1) && m.col[2];
    wire pool_w  = (code == DSP_POOL_OP);
    wire high_w  = (m.row == 3'h6) && (m.col == 3'h2);
    // map position used for coprocessor partner space
    wire cop_w   = (m.row == 3'h2) && (m.col == 3'h0);
    assign m.cop  = cop_w;
    assign m.attr = pool_w ? DSPCLS_ATTR_FIELD :
                    rsvd_w ? DSPCLS_ATTR_RSVD :
                    high_w ? DSPCLS_ATTR_HIGHER :
                    cop_w  ? DSPCLS_ATTR_PARTNER : DSPCLS_ATTR_VALID;
endmodule

// ---- dv/dspcls_exc_sink.sv ----
// model: exception logic that tallies the causes it is handed
`timescale 1ns/1ps
module dspcls_exc_sink
    import dspcls_pkg::*;
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    // verdict from the classifier
    input  wire logic        out_valid_i,
    input  wire dspcls_out_t outcome_i,
    input  wire dspcls_exc_t exc_cause_i,
    // tallies
    output int               ri_count_o,
    output int               cpu_count_o
);
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ri_count_o  <= 0;
            cpu_count_o <= 0;
        end else if (out_valid_i && outcome_i == DSPCLS_OUT_EXC) begin
            ri_count_o  <= ri_count_o + int'(exc_cause_i == DSPCLS_EXC_RI);
            cpu_count_o <= cpu_count_o + int'(exc_cause_i == DSPCLS_EXC_CPU);
        end
    end
endmodule

// ---- dv/tb_top.sv ----
// testbench: classifier fed word by word, verdicts checked from a queue
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb_top
    import dspcls_pkg::*;
;
    logic        clock_i, resetn_i, insn_valid_i, cop_usable_i;
    logic [31:0] insn_i;
    logic [2:0]  minor_attr_i;
    logic        out_valid_o, dsp_insn_o, obsolete_o;
    dspcls_out_t outcome_o;
    dspcls_exc_t exc_cause_o;
    logic [9:0]  minor_o;
    logic        r1_valid, r1_dsp, r1_obs;
    dspcls_out_t r1_outcome;
    dspcls_exc_t r1_cause;
    logic [9:0]  r1_minor;
    int          err_count, compares, exp_ri, exp_cpu, ri_n, cpu_n;
    logic [31:0] exp_q[$];
    logic [31:0] got_e;

    dspcls_top dut (.clock_i(clock_i), .resetn_i(resetn_i), .insn_valid_i(insn_valid_i),
        .insn_i(insn_i), .cop_usable_i(cop_usable_i), .minor_attr_i(minor_attr_i),
        .out_valid_o(out_valid_o), .outcome_o(outcome_o), .exc_cause_o(exc_cause_o),
        .dsp_insn_o(dsp_insn_o), .minor_o(minor_o), .obsolete_o(obsolete_o));
    // first-release variant without the extension, debug codes present
    dspcls_top #(.HAS_DSP(1'b0), .HAS_DEBUG(1'b1), .IS_REL2(1'b0)) dut_r1 (
        .clock_i(clock_i), .resetn_i(resetn_i), .insn_valid_i(insn_valid_i),
        .insn_i(insn_i), .cop_usable_i(cop_usable_i), .minor_attr_i(minor_attr_i),
        .out_valid_o(r1_valid), .outcome_o(r1_outcome), .exc_cause_o(r1_cause),
        .dsp_insn_o(r1_dsp), .minor_o(r1_minor), .obsolete_o(r1_obs));
    dspcls_exc_sink sink (.clock_i(clock_i), .resetn_i(resetn_i), .out_valid_i(out_valid_o),
        .outcome_i(outcome_o), .exc_cause_i(exc_cause_o), .ri_count_o(ri_n), .cpu_count_o(cpu_n));

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    // expected verdict: outcome, cause, dsp flag, obsolete flag, minor field
    // r1 selects the first-release variant without the extension
    function automatic logic [15:0] expect_of(logic [31:0] w, logic [2:0] a, logic cu,
                                              logic r1);
        logic [1:0] oc, ex;
        oc = DSPCLS_OUT_VALID;
        ex = DSPCLS_EXC_NONE;
        if (w[31:26] == 6'h00) begin
            if (a == 3'h1 || (r1 ? (a == 3'h2 || a == 3'h4) : a == 3'h3)) ex = DSPCLS_EXC_RI;
            else if (a >= 3'h6) oc = DSPCLS_OUT_FIELD;
        end else if ((w[31:30] == 2'h0 && w[28]) || w[31:26] == 6'h32) ex = DSPCLS_EXC_RI;
        else if (w[31:26] == 6'h10) ex = cu ? DSPCLS_EXC_RI : DSPCLS_EXC_CPU;
        if (ex != DSPCLS_EXC_NONE) oc = DSPCLS_OUT_EXC;
        return {oc, ex, !r1 && w[31:26] == 6'h00 && a == 3'h2, w[31:26] == 6'h00 && a == 3'h5,
                w[9:0]};
    endfunction

    task automatic drive(input logic v, input logic [31:0] w, input logic [2:0] a, input logic c);
        logic [31:0] e;
        @(posedge clock_i);
        #1;
        insn_valid_i = v;
        insn_i = w;
        minor_attr_i = a;
        cop_usable_i = c;
        e = {expect_of(w, a, c, 1'b1), expect_of(w, a, c, 1'b0)};
        if (v) begin
            exp_q.push_back(e);
            exp_ri += int'(e[13:12] == 2'h1);
            exp_cpu += int'(e[13:12] == 2'h2);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    always @(negedge clock_i) begin
        if (resetn_i && out_valid_o === 1'b1) begin
            if (exp_q.size() == 0) `CHK("spurious verdict", 1'b0, 1'b1)
            else begin
                got_e = exp_q.pop_front();
                `CHK("outcome", got_e[15:14], outcome_o)
                `CHK("cause", got_e[13:12], exc_cause_o)
                `CHK("flags", got_e[11:10], {dsp_insn_o, obsolete_o})
                `CHK("minor", got_e[9:0], minor_o)
                `CHK("r1 valid", 1'b1, r1_valid)
                `CHK("r1 outcome", got_e[31:30], r1_outcome)
                `CHK("r1 cause", got_e[29:28], r1_cause)
                `CHK("r1 flags", got_e[27:26], {r1_dsp, r1_obs})
                `CHK("r1 minor", got_e[25:16], r1_minor)
            end
        end
    end

    initial begin
        repeat (5000) @(posedge clock_i);
        err_count++;
        end_of_test;
    end

    initial begin
        void'($urandom(93));
        {insn_valid_i, insn_i, cop_usable_i, minor_attr_i} = '0;
        resetn_i = 1'b0;
        repeat (5) @(posedge clock_i);
        #1 resetn_i = 1'b1;
        for (int a = 0; a < 8; a++) drive(1'b1, {6'h00, 26'($urandom())}, 3'(a), 1'b1);
        for (int k = 0; k < 128; k++) drive(1'b1, {6'(k), 26'($urandom())}, 3'($urandom()), k[6]);
        // obsolete minor codes kept out of random traffic
        for (int k = 0; k < 200; k++) drive(1'(($urandom() % 4) != 0), $urandom(),
            3'(($urandom() % 5) == 4 ? 6 : $urandom() % 5), 1'($urandom()));
        drive(1'b0, 32'h0, 3'h0, 1'b0);
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        `CHK("pending verdicts", 0, exp_q.size())
        `CHK("ri count", exp_ri, ri_n)
        `CHK("cpu count", exp_cpu, cpu_n)
        end_of_test;
    end
endmodule
